// ---- logic/tws_master.sv ----
// bus master end of the two-wire control link
`timescale 1ns/10ps
`include "tws_params.svh"
module tws_master
   import tws_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // link
   tws_if.master           link,
   // command
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic       fast_mode,
   input  wire logic [6:0] cmd_dev,
   input  wire tws_byte_t  cmd_reg,
   input  wire tws_byte_t  cmd_wdata,
   // answer
   output logic            rsp_valid,
   output logic            rsp_nack,
   output tws_byte_t       rsp_data
);

   // ----------------------------------------------------------------------
   // data pin synchroniser and quarter-bit timer
   // ----------------------------------------------------------------------
   logic [1:0]  sda_sync_reg;
   logic [7:0]  qtr_reg;
   logic        fast_reg;
   tws_mstate_e state_reg;
   wire  logic  tick;
   wire  logic [7:0] qtr_load;

   assign qtr_load = fast_reg ? 8'(`TWS_FAST_QTR - 1) : 8'(`TWS_STD_QTR - 1);
   assign tick     = (qtr_reg == 8'h00) & (state_reg != TM_IDLE);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], link.serial_data_line};
      end
   end

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   tws_mstate_e state_next;
   logic [2:0]  ph_reg;
   logic [2:0]  ph_next;
   logic [3:0]  bit_reg;
   logic [3:0]  bit_next;
   logic [1:0]  step_reg;
   logic [1:0]  step_next;
   tws_byte_t   shift_reg;
   tws_byte_t   shift_next;
   logic        nack_next;
   logic        done_now;
   logic        read_reg;
   logic [6:0]  dev_reg;
   tws_byte_t   reg_reg;
   tws_byte_t   wdata_reg;
   logic        scl_reg;
   logic        sda_oe_reg;
   wire  logic  sda_s;
   wire  logic  accept;
   wire  logic  ph_last;
   wire  logic  scl_n;
   wire  logic  oe_n;

   assign sda_s     = sda_sync_reg[1];
   assign cmd_ready = (state_reg == TM_IDLE);
   assign accept    = cmd_valid & cmd_ready;
   // start and stop take six quarters for setup and bus-free margins
   assign ph_last   = (state_reg == TM_START) | (state_reg == TM_STOP)
                    ? (ph_reg == 3'h5) : (ph_reg == 3'h3);

   always_comb begin
      state_next = state_reg;
      ph_next    = ph_reg;
      bit_next   = bit_reg;
      step_next  = step_reg;
      shift_next = shift_reg;
      nack_next  = rsp_nack;
      done_now   = 1'b0;
      if (accept) begin
         state_next = TM_START;
         ph_next    = 3'h0;
         step_next  = 2'h0;
         nack_next  = 1'b0;
      end else if (tick && !ph_last) begin
         ph_next = ph_reg + 3'h1;
      end else if (tick) begin
         ph_next = 3'h0;
         unique case (state_reg)
            TM_IDLE: begin
            end
            TM_START: begin
               state_next = TM_TX;
               bit_next   = 4'h0;
               shift_next = {dev_reg, step_reg == 2'h3};
            end
            TM_TX: begin
               if (bit_reg != `TWS_BYTE_BITS) begin
                  bit_next   = bit_reg + 4'h1;
                  shift_next = {shift_reg[6:0], 1'b0};
               end else if (sda_s) begin
                  nack_next  = 1'b1;
                  state_next = TM_STOP;
               end else begin
                  bit_next = 4'h0;
                  unique case (step_reg)
                     2'h0: begin
                        step_next  = 2'h1;
                        shift_next = reg_reg;
                     end
                     2'h1: begin
                        if (read_reg) begin
                           // register address first, then turn round
                           step_next  = 2'h3;
                           state_next = TM_START;
                        end else begin
                           step_next  = 2'h2;
                           shift_next = wdata_reg;
                        end
                     end
                     2'h2: begin
                        state_next = TM_STOP;
                     end
                     2'h3: begin
                        state_next = TM_RX;
                     end
                  endcase
               end
            end
            TM_RX: begin
               if (bit_reg != `TWS_BYTE_BITS) begin
                  bit_next   = bit_reg + 4'h1;
                  shift_next = {shift_reg[6:0], sda_s};
               end else begin
                  state_next = TM_STOP;
               end
            end
            TM_STOP: begin
               state_next = TM_IDLE;
               done_now   = 1'b1;
            end
            default: begin
               state_next = TM_IDLE;
            end
         endcase
      end
   end

   // pin levels for the phase being entered
   assign scl_n = (state_next == TM_IDLE)
                | (((state_next == TM_START) | (state_next == TM_STOP))
                   & (ph_next != 3'h0))
                | (((state_next == TM_TX) | (state_next == TM_RX))
                   & ph_next[1]);
   // single-byte read ends with a released (not acknowledged) ninth bit
   assign oe_n  = ((state_next == TM_START) & (ph_next >= 3'h3))
                | ((state_next == TM_STOP) & (ph_next <= 3'h2))
                | ((state_next == TM_TX) & (bit_next != `TWS_BYTE_BITS)
                   & ~shift_next[7]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= TM_IDLE;
         ph_reg    <= 3'h0;
         bit_reg   <= 4'h0;
         step_reg  <= 2'h0;
         shift_reg <= 8'h00;
         qtr_reg   <= 8'h00;
         rsp_nack  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ph_reg    <= ph_next;
         bit_reg   <= bit_next;
         step_reg  <= step_next;
         shift_reg <= shift_next;
         rsp_nack  <= nack_next;
         qtr_reg   <= (accept | tick) ? qtr_load : qtr_reg - 8'h01;
         if (accept) begin
            qtr_reg <= fast_mode ? 8'(`TWS_FAST_QTR - 1)
                                 : 8'(`TWS_STD_QTR - 1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fast_reg  <= 1'b0;
         read_reg  <= 1'b0;
         dev_reg   <= 7'h00;
         reg_reg   <= 8'h00;
         wdata_reg <= 8'h00;
      end else if (accept) begin
         fast_reg  <= fast_mode;
         read_reg  <= cmd_read;
         dev_reg   <= cmd_dev;
         reg_reg   <= cmd_reg;
         wdata_reg <= cmd_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_reg    <= 1'b1;
         sda_oe_reg <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
      end else begin
         rsp_valid <= done_now;
         if (done_now) begin
            rsp_data <= shift_reg;
         end
         if (accept | tick) begin
            scl_reg    <= scl_n;
            sda_oe_reg <= oe_n;
         end
      end
   end

   assign link.serial_clock_line = scl_reg; // R2
   assign link.m_sda_o           = 1'b0;
   assign link.m_sda_oe          = sda_oe_reg;

endmodule // tws_master

// ---- inc/tws_params.svh ----
// timing, address and reset constants of the two-wire register link
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define TWS_CLK_HZ      100000000
`define TWS_CLK_NS      10

// ----------------------------------------------------------------------
// link rates and derived quarter-bit counts
// ----------------------------------------------------------------------
`define TWS_STD_HZ      100000
`define TWS_FAST_HZ     400000
`define TWS_FAST_LOW_NS 1300
// standard: a quarter of the bit period, rounded up
`define TWS_STD_QTR  ((`TWS_CLK_HZ + 4 * `TWS_STD_HZ - 1) / (4 * `TWS_STD_HZ))
// fast: two quarters must cover the least low time, so rate ends below 400k
`define TWS_FAST_QTR ((`TWS_FAST_LOW_NS + 2 * `TWS_CLK_NS - 1) / (2 * `TWS_CLK_NS))

// ----------------------------------------------------------------------
// slave data hold after clock fall, least time rounded up
// ----------------------------------------------------------------------
`define TWS_HOLD_NS     300
`define TWS_HOLD_CYC    ((`TWS_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

// ----------------------------------------------------------------------
// addressing and reset values
// ----------------------------------------------------------------------
`define TWS_SLAVE_ADDR  7'h10
`define TWS_REG_RESET   8'h00
`define TWS_BYTE_BITS   4'h8

`endif

// ---- inc/tws_pkg.sv ----
// types shared by both ends of the two-wire register link
package tws_pkg;

   typedef logic [7:0] tws_byte_t;

   // slave states, gray along the listed order
   typedef enum logic [2:0] {
      TS_IDLE = 3'h0,
      TS_DEV  = 3'h1,
      TS_DACK = 3'h3,
      TS_RADR = 3'h2,
      TS_WDAT = 3'h6,
      TS_WACK = 3'h7,
      TS_RDAT = 3'h5,
      TS_MACK = 3'h4
   } tws_sstate_e;

   // master states
   typedef enum logic [2:0] {
      TM_IDLE  = 3'h0,
      TM_START = 3'h1,
      TM_TX    = 3'h3,
      TM_RX    = 3'h2,
      TM_STOP  = 3'h6
   } tws_mstate_e;

endpackage

// ---- inc/tws_if.sv ----
// two-wire link between bus master and register slave
`timescale 1ns/10ps
interface tws_if;
   logic serial_clock_line;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic serial_data_line;

   // open drain with pull-up: low while any party drives
   assign serial_data_line = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport master (
      output serial_clock_line,
      output m_sda_o,
      output m_sda_oe,
      input  serial_data_line
   );

   modport slave (
      input  serial_clock_line,
      output s_sda_o,
      output s_sda_oe,
      input  serial_data_line
   );
endinterface

// ---- logic/tws_slave.sv ----
// register slave end of the two-wire control link
// Function
// [R1] slave only, master reads and writes registers
// [R2] master clocks; slave samples clock as input
// [R3] open-drain data, drive low only when owned
// [R4] works at standard or fast rate
// [R5] start, repeated start, stop, per-byte acknowledge
// [R6] read follows write carrying register address
// [R7] own address only; ack bytes, release for master
`timescale 1ns/10ps
`include "tws_params.svh"
module tws_slave
   import tws_pkg::*;
(
   // clock and reset
   input  wire logic      core_clk,
   input  wire logic      rst,
   // link
   tws_if.slave           link,
   // register write notice
   output logic           reg_wr_stb,
   output tws_byte_t      reg_wr_addr,
   output tws_byte_t      reg_wr_data,
   // local status update
   input  wire logic      stat_we,
   input  wire tws_byte_t stat_addr,
   input  wire tws_byte_t stat_data
);

   // ----------------------------------------------------------------------
   // pin synchronisers and condition detect
   // ----------------------------------------------------------------------
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;
   wire  logic scl_s;
   wire  logic sda_s;
   wire  logic scl_rise;
   wire  logic scl_fall;
   wire  logic start_det;
   wire  logic stop_det;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], link.serial_clock_line}; // R2
         sda_sync_reg <= {sda_sync_reg[0], link.serial_data_line};
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end

   assign scl_s     = scl_sync_reg[1];
   assign sda_s     = sda_sync_reg[1];
   // edge-driven, so any rate up to fast mode is followed
   assign scl_rise  = scl_s & ~scl_prev_reg; // R4
   assign scl_fall  = ~scl_s & scl_prev_reg;
   assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // R5
   assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // R5

   // ----------------------------------------------------------------------
   // state and register storage
   // ----------------------------------------------------------------------
   tws_sstate_e state_reg;
   tws_sstate_e state_next;
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   tws_byte_t   shift_reg;
   tws_byte_t   shift_next;
   tws_byte_t   ptr_reg;
   tws_byte_t   ptr_next;
   logic        rw_reg;
   logic        rw_next;
   logic        mack_reg;
   logic        mack_next;
   logic        wr_now;
   tws_byte_t   regs [256];
   wire  tws_byte_t ptr_inc;
   wire  logic      byte_done;
   wire  logic      addr_hit;

   assign ptr_inc   = ptr_reg + 8'h01;
   assign byte_done = scl_fall & (cnt_reg == `TWS_BYTE_BITS);
   assign addr_hit  = (shift_reg[7:1] == `TWS_SLAVE_ADDR); // R7

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      ptr_next   = ptr_reg;
      rw_next    = rw_reg;
      mack_next  = mack_reg;
      wr_now     = 1'b0;
      if (start_det) begin
         // repeated start keeps the pointer for the read phase
         state_next = TS_DEV; // R5
         cnt_next   = 4'h0;
      end else if (stop_det) begin
         state_next = TS_IDLE; // R5
      end else begin
         unique case (state_reg)
            TS_IDLE: begin
            end
            TS_DEV, TS_RADR, TS_WDAT: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next   = cnt_reg + 4'h1;
               end else if (byte_done) begin
                  cnt_next = 4'h0;
                  if (state_reg == TS_DEV) begin
                     rw_next    = shift_reg[0];
                     state_next = addr_hit ? TS_DACK : TS_IDLE; // R7
                  end else if (state_reg == TS_RADR) begin
                     ptr_next   = shift_reg; // R6
                     state_next = TS_WACK;
                  end else begin
                     wr_now     = 1'b1; // R1
                     ptr_next   = ptr_inc;
                     state_next = TS_WACK;
                  end
               end
            end
            TS_DACK: begin
               if (scl_fall) begin
                  if (rw_reg) begin
                     shift_next = regs[ptr_reg]; // R6
                     state_next = TS_RDAT;
                  end else begin
                     state_next = TS_RADR;
                  end
               end
            end
            TS_WACK: begin
               if (scl_fall) begin
                  state_next = TS_WDAT;
               end
            end
            TS_RDAT: begin
               if (scl_fall) begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  cnt_next   = cnt_reg + 4'h1;
                  if (cnt_reg == 4'h7) begin
                     cnt_next   = 4'h0;
                     state_next = TS_MACK; // R7
                  end
               end
            end
            TS_MACK: begin
               if (scl_rise) begin
                  mack_next = ~sda_s;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     ptr_next   = ptr_inc;
                     shift_next = regs[ptr_inc];
                     state_next = TS_RDAT;
                  end else begin
                     // master declined more; wait for stop
                     state_next = TS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= TS_IDLE;
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg   <= 8'h00;
         rw_reg    <= 1'b0;
         mack_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg   <= ptr_next;
         rw_reg    <= rw_next;
         mack_reg  <= mack_next;
      end
   end

   // ----------------------------------------------------------------------
   // register array; bus write wins over local update
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 256; i++) begin
            regs[i] <= `TWS_REG_RESET;
         end
      end else if (wr_now) begin
         regs[ptr_reg] <= shift_reg; // R1
      end else if (stat_we) begin
         regs[stat_addr] <= stat_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_wr_stb  <= 1'b0;
         reg_wr_addr <= 8'h00;
         reg_wr_data <= 8'h00;
      end else begin
         reg_wr_stb <= wr_now;
         if (wr_now) begin
            reg_wr_addr <= ptr_reg;
            reg_wr_data <= shift_reg;
         end
      end
   end

   // ----------------------------------------------------------------------
   // data drive with hold after clock fall
   // ----------------------------------------------------------------------
   logic       sda_oe_reg;
   logic [4:0] hold_reg;
   wire  logic oe_want;

   // owned phases only: address/data ack, and zero bits of read data
   assign oe_want = (state_reg == TS_DACK) | (state_reg == TS_WACK)
                  | ((state_reg == TS_RDAT) & ~shift_reg[7]); // R3

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_reg   <= 5'h00;
         sda_oe_reg <= 1'b0;
      end else if (scl_fall) begin
         // data must not move near the falling edge seen by the master
         hold_reg <= 5'(`TWS_HOLD_CYC);
      end else if (hold_reg != 5'h00) begin
         hold_reg <= hold_reg - 5'h01;
      end else begin
         sda_oe_reg <= oe_want; // R3
      end
   end

   assign link.s_sda_o  = 1'b0;
   assign link.s_sda_oe = sda_oe_reg;

endmodule // tws_slave

// ---- dv/tws_assertions.sv ----
// checker of ownership and timing on the two-wire link
`timescale 1ns/10ps
module tws_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link
   input wire logic serial_clock_line,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic serial_data_line
);
   // ---------------------------------------------------------------
   // edge counters, saturating so long idles cannot wrap
   // ---------------------------------------------------------------
   logic       scl_q_reg;
   logic [7:0] run_cnt_reg;
   logic [7:0] fall_cnt_reg;
   logic [7:0] run_cnt_next;
   logic [7:0] fall_cnt_next;
   wire        scl_chg  = scl_q_reg ^ serial_clock_line;
   wire        scl_fall = scl_q_reg & ~serial_clock_line;
   wire        run_sat  = run_cnt_reg == 8'hFF;
   wire        fall_sat = fall_cnt_reg == 8'hFF;

   assign run_cnt_next  = scl_chg ? 8'h00 :
                          (run_sat ? run_cnt_reg : run_cnt_reg + 8'h01);
   assign fall_cnt_next = scl_fall ? 8'h00 :
                          (fall_sat ? fall_cnt_reg : fall_cnt_reg + 8'h01);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_q_reg    <= 1'b1;
         run_cnt_reg  <= 8'hFF;
         fall_cnt_reg <= 8'hFF;
      end else begin
         scl_q_reg    <= serial_clock_line;
         run_cnt_reg  <= run_cnt_next;
         fall_cnt_reg <= fall_cnt_next;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_start;
      serial_clock_line && $fell(serial_data_line);
   endsequence
   sequence s_stop;
      serial_clock_line && $rose(serial_data_line);
   endsequence
   sequence s_slave_quiet;
      !s_sda_oe ##1 !s_sda_oe;
   endsequence

   property p_reset_idle;
      disable iff (1'b0)
      rst |=> serial_clock_line && !m_sda_oe && !s_sda_oe;
   endproperty
   property p_drive_low_only;
      (m_sda_oe || s_sda_oe) |-> !(m_sda_oe && m_sda_o) && !(s_sda_oe && s_sda_o);
   endproperty
   property p_slave_steady_high;
      $changed(s_sda_oe) |-> !serial_clock_line;
   endproperty
   property p_slave_hold;
      $changed(s_sda_oe) |-> fall_cnt_reg inside {[8'd28:8'd40]};
   endproperty
   property p_scl_phase;
      $changed(serial_clock_line) |-> run_cnt_reg >= 8'd63;
   endproperty
   property p_no_contend;
      s_sda_oe && serial_clock_line |-> !m_sda_oe;
   endproperty
   property p_stop_release;
      s_stop |-> s_slave_quiet;
   endproperty
   property p_start_release;
      s_start |-> s_slave_quiet;
   endproperty

   a_reset_idle:        assert property (p_reset_idle)
      else $error("link not idle after reset");
   a_drive_low_only:    assert property (p_drive_low_only)
      else $error("data line driven high");
   a_slave_steady_high: assert property (p_slave_steady_high)
      else $error("slave moved data while clock high");
   a_slave_hold:        assert property (p_slave_hold)
      else $error("slave data change off hold time");
   a_scl_phase:         assert property (p_scl_phase)
      else $error("clock phase shorter than a quarter");
   a_no_contend:        assert property (p_no_contend)
      else $error("both ends own data line");
   a_stop_release:      assert property (p_stop_release)
      else $error("slave drives at stop");
   a_start_release:     assert property (p_start_release)
      else $error("slave drives at start");
endmodule // tws_assertions

// ---- dv/tws_tb_top.sv ----
// self-checking bench joining master and slave over the link
`timescale 1ns/10ps
`include "tws_params.svh"
module tws_tb_top import tws_pkg::*;;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int CYC_MAX = 95000;
   localparam int W_STD = 120 * `TWS_STD_QTR + 1;
   localparam int W_FST = 120 * `TWS_FAST_QTR + 1;
   // read: two starts, four bytes of nine bits, stop
   localparam int R_STD = 162 * `TWS_STD_QTR + 1;
   localparam int R_FST = 162 * `TWS_FAST_QTR + 1;
   logic       core_clk;
   logic       rst;
   logic       cmd_valid;
   logic       cmd_ready;
   logic       cmd_read;
   logic       fast_mode;
   logic [6:0] cmd_dev;
   tws_byte_t  cmd_reg;
   tws_byte_t  cmd_wdata;
   logic       rsp_valid;
   logic       rsp_nack;
   tws_byte_t  rsp_data;
   logic       reg_wr_stb;
   tws_byte_t  reg_wr_addr;
   tws_byte_t  reg_wr_data;
   logic       stat_we;
   tws_byte_t  stat_addr;
   tws_byte_t  stat_data;
   int         n_fail;
   int         tests_run;
   int         n_stb;
   int         cyc;
   int         lat;

   tws_if link_if();

   tws_slave u_tws_slave (
      .core_clk(core_clk), .rst(rst), .link(link_if),
      .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .stat_we(stat_we),
      .stat_addr(stat_addr), .stat_data(stat_data));
   tws_master u_tws_master (
      .core_clk(core_clk), .rst(rst), .link(link_if),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
      .fast_mode(fast_mode), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
      .rsp_data(rsp_data));
   tws_assertions u_tws_assertions (
      .core_clk(core_clk), .rst(rst),
      .serial_clock_line(link_if.serial_clock_line),
      .m_sda_o(link_if.m_sda_o), .m_sda_oe(link_if.m_sda_oe),
      .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe),
      .serial_data_line(link_if.serial_data_line));

   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (reg_wr_stb === 1'b1) begin
         n_stb++;
      end
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic judge(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == CYC_MAX) begin
         n_fail++;
         close_out();
      end
   end

   // one command, entered just after an edge; lat counts to the answer
   task automatic do_cmd(input logic rd, input logic fm,
                         input logic [6:0] dev, input tws_byte_t rg,
                         input tws_byte_t wd);
      judge(cmd_ready === 1'b1, "master not ready");
      cmd_read  = rd;
      fast_mode = fm;
      cmd_dev   = dev;
      cmd_reg   = rg;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 50000) begin
         @(posedge core_clk);
         #1;
         lat++;
      end
      judge(rsp_valid === 1'b1, "no answer");
   endtask

   task automatic t_write_read_fast;
      int n0;
      n0 = n_stb;
      do_cmd(1'b0, 1'b1, `TWS_SLAVE_ADDR, 8'h05, 8'hA5);
      judge(rsp_nack === 1'b0, "write not acked");
      judge(n_stb == n0 + 1, "write strobe count");
      judge(reg_wr_addr === 8'h05 && reg_wr_data === 8'hA5, "write");
      judge(lat >= W_FST - 2 && lat <= W_FST + 2, "write length");
      do_cmd(1'b1, 1'b1, `TWS_SLAVE_ADDR, 8'h05, 8'h00);
      judge(rsp_nack === 1'b0 && rsp_data === 8'hA5, "read back");
      judge(lat >= R_FST - 2 && lat <= R_FST + 2, "read length");
   endtask

   task automatic t_foreign_addr;
      int n0;
      n0 = n_stb;
      do_cmd(1'b0, 1'b1, `TWS_SLAVE_ADDR ^ 7'h01, 8'h06, 8'h5A);
      judge(rsp_nack === 1'b1, "foreign address acked");
      judge(n_stb == n0, "foreign write landed");
      judge(lat < W_FST - 2, "no early stop");
      do_cmd(1'b1, 1'b1, `TWS_SLAVE_ADDR, 8'h06, 8'h00);
      judge(rsp_data === 8'h00, "register changed");
   endtask

   task automatic t_local_status;
      stat_addr = 8'hFF;
      stat_data = 8'h3C;
      stat_we   = 1'b1;
      @(posedge core_clk);
      #1;
      stat_we = 1'b0;
      do_cmd(1'b1, 1'b1, `TWS_SLAVE_ADDR, 8'hFF, 8'h00);
      judge(rsp_data === 8'h3C, "status read");
   endtask

   task automatic t_std_read;
      do_cmd(1'b1, 1'b0, `TWS_SLAVE_ADDR, 8'h05, 8'h00);
      judge(rsp_nack === 1'b0 && rsp_data === 8'hA5, "slow read");
      judge(lat >= R_STD - 2 && lat <= R_STD + 2, "slow length");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      n_fail    = 0;
      tests_run = 0;
      n_stb     = 0;
      cyc       = 0;
      lat       = 0;
      rst       = 1'b1;
      cmd_valid = 1'b0;
      cmd_read  = 1'b0;
      fast_mode = 1'b1;
      cmd_dev   = 7'h00;
      cmd_reg   = 8'h00;
      cmd_wdata = 8'h00;
      stat_we   = 1'b0;
      stat_addr = 8'h00;
      stat_data = 8'h00;
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_write_read_fast();
      t_foreign_addr();
      t_local_status();
      t_std_read();
      close_out();
   end
endmodule // tws_tb_top
